/* File: rtl/cwt_consts.svh */
`ifndef CWT_CONSTS_SVH
`define CWT_CONSTS_SVH

// Register offsets
`define CWT_OFS_CH5_CUTOFF     8'h65
`define CWT_OFS_CH6_FAST_UNDER 8'h70
`define CWT_OFS_CH6_FAST_OVER  8'h71
`define CWT_OFS_CH6_SLOW_UNDER 8'h72
`define CWT_OFS_CH6_SLOW_OVER  8'h73

// Reset values
`define CWT_RST_CH5_CUTOFF     8'h14
`define CWT_RST_UNDER          8'h00
`define CWT_RST_OVER           8'hff
`define CWT_RST_CUTOFF_CODE    3'h4

// Fields of the cutoff and mapping register
`define CWT_CUTOFF_MSB         2
`define CWT_CUTOFF_LSB         0
`define CWT_MAP_MSB            4
`define CWT_MAP_LSB            3
`define CWT_MAP_UNDER_BIT      0
`define CWT_MAP_OVER_BIT       1
`define CWT_WRITABLE_MASK      8'h1f

// Threshold scaling, millivolts
`define CWT_BASE_1X_MV         13'h00c8
`define CWT_STEP_1X_MV         13'h0005
`define CWT_BASE_4X_MV         13'h0320
`define CWT_STEP_4X_MV         13'h0014

`endif

/* File: rtl/cwt_pkg.sv */
package cwt_pkg;

	typedef enum logic [2:0]
	{
		CWT_FC_250HZ = 3'h2,
		CWT_FC_500HZ = 3'h3,
		CWT_FC_1KHZ  = 3'h4,
		CWT_FC_2KHZ  = 3'h5,
		CWT_FC_4KHZ  = 3'h6
	} cwt_cutoff_type;

	typedef enum logic
	{
		CWT_SCALE_1X = 1'b0,
		CWT_SCALE_4X = 1'b1
	} cwt_scale_type;

endpackage : cwt_pkg

/* File: rtl/cwt_regs.sv */
// Notes on behaviour
// - Bits 4:3 map fast faults to reset
// - Mapping only acts with reset pin variant
// - Bits 2:0 select slow cutoff; some invalid
// - Cutoff code reconfigures slow path lowpass
// - Cutoff register at 0x65, resets 0x14
// - Threshold meaning follows range multiplier scaling
// - 1x: 0.2V base, 5mV steps
// - 4x: 0.8V base, 20mV steps
// - Fast path limits at 0x70, 0x71
// - Slow path limits at 0x72, 0x73
// - Under limits reset to 0x00
// - Over limits reset to 0xff
`include "cwt_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cwt_regs
#(
	parameter bit HAS_RESET_PIN = 1'b1
)
(
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic [7:0]             reg_addr_in,
	input  wire logic                   reg_wr_in,
	input  wire logic [7:0]             reg_wdata_in,
	output logic      [7:0]             reg_rdata_out,
	input  wire cwt_pkg::cwt_scale_type range_multiplier_in,
	input  wire logic [7:0]             fast_meas_in,
	input  wire logic [7:0]             slow_meas_in,
	output var cwt_pkg::cwt_cutoff_type slow_path_cutoff_out,
	output logic                        cutoff_invalid_out,
	output logic      [12:0]            fast_under_mv_out,
	output logic      [12:0]            fast_over_mv_out,
	output logic      [12:0]            slow_under_mv_out,
	output logic      [12:0]            slow_over_mv_out,
	output logic                        fast_under_fault_out,
	output logic                        fast_over_fault_out,
	output logic                        slow_under_fault_out,
	output logic                        slow_over_fault_out,
	output logic                        reset_out_n_out
);
	import cwt_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic       rst_meta_n;
	logic       rst_n;

	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [4:0] cutoff_map;
	logic [7:0] fast_under_limit;
	logic [7:0] fast_over_limit;
	logic [7:0] slow_under_limit;
	logic [7:0] slow_over_limit;

	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			cutoff_map <= 5'(`CWT_RST_CH5_CUTOFF);
		else if (reg_wr_in && reg_addr_in == `CWT_OFS_CH5_CUTOFF)
			cutoff_map <= 5'(reg_wdata_in & `CWT_WRITABLE_MASK);
	end

	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_under_limit <= `CWT_RST_UNDER;
			fast_over_limit  <= `CWT_RST_OVER;
			slow_under_limit <= `CWT_RST_UNDER;
			slow_over_limit  <= `CWT_RST_OVER;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == `CWT_OFS_CH6_FAST_UNDER)
				fast_under_limit <= reg_wdata_in;
			if (reg_addr_in == `CWT_OFS_CH6_FAST_OVER)
				fast_over_limit <= reg_wdata_in;
			if (reg_addr_in == `CWT_OFS_CH6_SLOW_UNDER)
				slow_under_limit <= reg_wdata_in;
			if (reg_addr_in == `CWT_OFS_CH6_SLOW_OVER)
				slow_over_limit <= reg_wdata_in;
		end
	end

	// Reserved bits read zero; unmapped offsets read zero
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_out <= 8'h00;
		else
		begin
			unique case (reg_addr_in)
				`CWT_OFS_CH5_CUTOFF:     reg_rdata_out <= {3'h0, cutoff_map};
				`CWT_OFS_CH6_FAST_UNDER: reg_rdata_out <= fast_under_limit;
				`CWT_OFS_CH6_FAST_OVER:  reg_rdata_out <= fast_over_limit;
				`CWT_OFS_CH6_SLOW_UNDER: reg_rdata_out <= slow_under_limit;
				`CWT_OFS_CH6_SLOW_OVER:  reg_rdata_out <= slow_over_limit;
				default:                 reg_rdata_out <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slow path filter setting

	logic [2:0] cutoff_code;
	logic       cutoff_valid;

	assign cutoff_code  = cutoff_map[`CWT_CUTOFF_MSB:`CWT_CUTOFF_LSB];
	assign cutoff_valid = cutoff_code inside {CWT_FC_250HZ, CWT_FC_500HZ, CWT_FC_1KHZ,
		CWT_FC_2KHZ, CWT_FC_4KHZ};

	// Invalid codes keep the last good filter, never a bogus response
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slow_path_cutoff_out <= cwt_cutoff_type'(`CWT_RST_CUTOFF_CODE);
			cutoff_invalid_out   <= 1'b0;
		end
		else
		begin
			cutoff_invalid_out <= !cutoff_valid;
			if (cutoff_valid)
				slow_path_cutoff_out <= cwt_cutoff_type'(cutoff_code);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Threshold voltages and comparisons

	logic [7:0]  limit_code [4];
	logic [12:0] limit_mv   [4];

	assign limit_code[0] = fast_under_limit;
	assign limit_code[1] = fast_over_limit;
	assign limit_code[2] = slow_under_limit;
	assign limit_code[3] = slow_over_limit;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_mv
			logic [12:0] next_mv;
			always_comb
			begin
				if (range_multiplier_in == CWT_SCALE_4X)
					next_mv = 13'(`CWT_BASE_4X_MV + `CWT_STEP_4X_MV * {5'h00, limit_code[gi]});
				else
					next_mv = 13'(`CWT_BASE_1X_MV + `CWT_STEP_1X_MV * {5'h00, limit_code[gi]});
			end
			always_ff @(posedge ref_clk_in or negedge rst_n)
			begin
				if (!rst_n)
					limit_mv[gi] <= 13'h0000;
				else
					limit_mv[gi] <= next_mv;
			end
		end
	endgenerate

	assign fast_under_mv_out = limit_mv[0];
	assign fast_over_mv_out  = limit_mv[1];
	assign slow_under_mv_out = limit_mv[2];
	assign slow_over_mv_out  = limit_mv[3];

	// Both sides share one scale, so codes compare directly
	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_under_fault_out <= 1'b0;
			fast_over_fault_out  <= 1'b0;
			slow_under_fault_out <= 1'b0;
			slow_over_fault_out  <= 1'b0;
		end
		else
		begin
			fast_under_fault_out <= fast_meas_in < fast_under_limit;
			fast_over_fault_out  <= fast_meas_in > fast_over_limit;
			slow_under_fault_out <= slow_meas_in < slow_under_limit;
			slow_over_fault_out  <= slow_meas_in > slow_over_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset output

	logic [1:0] fault_map;
	logic       next_reset_n;

	assign fault_map = cutoff_map[`CWT_MAP_MSB:`CWT_MAP_LSB];

	always_comb
	begin
		next_reset_n = 1'b1;
		if (HAS_RESET_PIN)
			next_reset_n = !((fault_map[`CWT_MAP_UNDER_BIT] && fast_under_fault_out) ||
				(fault_map[`CWT_MAP_OVER_BIT] && fast_over_fault_out));
	end

	always_ff @(posedge ref_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			reset_out_n_out <= 1'b1;
		else
			reset_out_n_out <= next_reset_n;
	end

endmodule : cwt_regs

`default_nettype wire

/* File: tb/cwt_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cwt_regs_asserts
(
	input wire logic                   ref_clk_in,
	input wire logic                   rst_n_in,
	input wire logic [7:0]             reg_addr_in,
	input wire logic [7:0]             reg_rdata_out,
	input wire cwt_pkg::cwt_scale_type range_multiplier_in,
	input wire logic [7:0]             fast_meas_in,
	input wire cwt_pkg::cwt_cutoff_type slow_path_cutoff_out,
	input wire logic                   cutoff_invalid_out,
	input wire logic [12:0]            fast_under_mv_out,
	input wire logic [12:0]            fast_over_mv_out,
	input wire logic                   fast_under_fault_out,
	input wire logic                   fast_over_fault_out,
	input wire logic                   reset_out_n_out
);
	import cwt_pkg::*;
	// Outputs settle within two edges after the design's own reset copy lifts
	logic [3:0] up;
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in)
			up <= 4'h0;
		else
			up <= {up[2:0], 1'b1};
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!up[3]);
	a_reserved_zero: assert property (
		reg_addr_in == 8'h65 |=> reg_rdata_out[7:5] == 3'h0) else $error("reserved");
	a_no_map_fault: assert property (
		!fast_under_fault_out && !fast_over_fault_out |=> reset_out_n_out) else $error("rst");
	a_rst_has_cause: assert property (
		!reset_out_n_out |-> $past(fast_under_fault_out || fast_over_fault_out))
		else $error("cause");
	a_cutoff_legal: assert property (
		slow_path_cutoff_out inside {[3'h2:3'h6]}) else $error("cutoff");
	a_invalid_hold: assert property (
		cutoff_invalid_out && $past(cutoff_invalid_out) |-> $stable(slow_path_cutoff_out))
		else $error("hold");
	a_span_low: assert property (
		!range_multiplier_in && $stable(range_multiplier_in) |-> fast_over_mv_out
		inside {[13'h00c8:13'h05c3]}) else $error("span 1x");
	a_span_high: assert property (
		range_multiplier_in && $stable(range_multiplier_in) |-> fast_over_mv_out
		inside {[13'h0320:13'h170c]}) else $error("span 4x");
	a_under_fault: assert property (
		!range_multiplier_in && $stable(range_multiplier_in) |-> fast_under_fault_out ==
		($past(fast_meas_in) < (fast_under_mv_out - 13'h00c8) / 13'h0005)) else $error("uv");
	a_over_fault: assert property (
		!range_multiplier_in && $stable(range_multiplier_in) |-> fast_over_fault_out ==
		($past(fast_meas_in) > (fast_over_mv_out - 13'h00c8) / 13'h0005)) else $error("ov");
	c_under: cover property (fast_under_fault_out);
	c_rst: cover property (!reset_out_n_out);
	c_inv: cover property (cutoff_invalid_out);
endmodule : cwt_regs_asserts
`default_nettype wire

/* File: tb/cwt_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cwt_regs_test;
	import cwt_pkg::*;
	logic           ref_clk_in = 1'b0;
	logic           rst_n_in = 1'b0;
	logic           reg_wr_in = 1'b0;
	logic [7:0]     reg_addr_in = 8'h00, reg_wdata_in = 8'h00, fm = 8'h00, sm = 8'h00, rd;
	cwt_scale_type  rm = CWT_SCALE_1X;
	cwt_cutoff_type co;
	logic           inv, fu, fo, su, so, ro, ro_pinless;
	logic [12:0]    mv [4];
	logic [7:0]     cut = 8'h14;
	logic [31:0]    sd = 32'h7d2e;
	int             fail_count, samples_checked, cyc, lv = 4, rg [4] = '{0, 255, 0, 255};
	always #25 ref_clk_in = ~ref_clk_in;
	cwt_regs i_dut (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
		.reg_rdata_out(rd), .range_multiplier_in(rm), .fast_meas_in(fm), .slow_meas_in(sm),
		.slow_path_cutoff_out(co), .cutoff_invalid_out(inv), .fast_under_mv_out(mv[0]),
		.fast_over_mv_out(mv[1]), .slow_under_mv_out(mv[2]), .slow_over_mv_out(mv[3]),
		.fast_under_fault_out(fu), .fast_over_fault_out(fo), .slow_under_fault_out(su),
		.slow_over_fault_out(so), .reset_out_n_out(ro));
	// Variant without the reset pin must ignore the mapping field
	cwt_regs #(.HAS_RESET_PIN(1'b0)) i_dut_pinless (.ref_clk_in, .rst_n_in, .reg_addr_in,
		.reg_wr_in, .reg_wdata_in, .reg_rdata_out(), .range_multiplier_in(rm),
		.fast_meas_in(fm), .slow_meas_in(sm), .slow_path_cutoff_out(),
		.cutoff_invalid_out(), .fast_under_mv_out(), .fast_over_mv_out(),
		.slow_under_mv_out(), .slow_over_mv_out(), .fast_under_fault_out(),
		.fast_over_fault_out(), .slow_under_fault_out(), .slow_over_fault_out(),
		.reset_out_n_out(ro_pinless));
	////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd[7:0];
	endfunction : rnd
	task automatic chk(logic [12:0] got, int exp);
		samples_checked++;
		if (got !== 13'(exp))
		begin
			fail_count++;
			$display("ERROR %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge ref_clk_in);
		reg_wr_in = 1'b0;
		// Reserved bits are dropped by the device
		if (a == 8'h65)
			cut = d & 8'h1f;
		else if (a[7:2] == 6'h1c)
			rg[a[1:0]] = d;
		if (cut[2:0] inside {[3'h2:3'h6]})
			lv = cut[2:0];
	endtask : wr
	task automatic rdc(logic [7:0] a, int exp);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		repeat (2) @(negedge ref_clk_in);
		chk(rd, exp);
	endtask : rdc
	task give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (10) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		for (int i = 0; i < 4; i++)
			rdc(8'(8'h70 + i), rg[i]);
		rdc(8'h65, cut);
		for (int i = 0; i < 4; i++)
			chk(mv[i], 200 + 5 * rg[i]);
		chk(co, lv);
		chk(inv, 0);
		chk(ro, 1);
		$display("reset test done");
		wr(8'h66, 8'hff);
		rdc(8'h66, 0);
		// Walk all cutoff codes and all four mappings
		for (int n = 0; n < 32; n++)
		begin
			rm = cwt_scale_type'(n % 2);
			fm = rnd();
			sm = rnd();
			wr(8'h65, {3'(rnd()), 2'(n / 8), 3'(n)});
			wr(8'(8'h70 + n % 4), rnd());
			repeat (3) @(negedge ref_clk_in);
			rdc(8'h65, cut);
			rdc(8'(8'h70 + n % 4), rg[n % 4]);
			for (int i = 0; i < 4; i++)
				chk(mv[i], rm ? 800 + 20 * rg[i] : 200 + 5 * rg[i]);
			chk(fu, fm < rg[0]);
			chk(fo, fm > rg[1]);
			chk(su, sm < rg[2]);
			chk(so, sm > rg[3]);
			chk(ro, !(cut[3] && fm < rg[0] || cut[4] && fm > rg[1]));
			chk(ro_pinless, 1);
			chk(co, lv);
			chk(inv, lv != cut[2:0]);
		end
		$display("random test done");
		give_verdict();
	end
endmodule : cwt_regs_test
bind cwt_regs cwt_regs_asserts i_chk (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_rdata_out,
	.range_multiplier_in, .fast_meas_in, .slow_path_cutoff_out, .cutoff_invalid_out,
	.fast_under_mv_out, .fast_over_mv_out, .fast_under_fault_out, .fast_over_fault_out,
	.reset_out_n_out);
`default_nettype wire
